/* logic/vss_sequencer.sv */
// Start-up, soft-start and protection sequencer for a multiphase regulator.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Undervoltage on the 5 V supply or ramp supply prevents or aborts regulation.
// - Driver enable pulled low returns phases to mid-level and restarts soft-start.
// - A counter steps the reference code from zero to target at fixed slew.
// - Before enabling, phases stay open with a test current to detect phase count.
// - After configuration, all phase outputs go to the 2.0 V mid-level state.
// - Then driver enable asserts, compensation releases, and the ramp begins.
// - Each detected phase stays mid-level until its first pulse; an undetected phase stays mid-level.
// - Total current limit scales with active phase count in reduced-phase mode.
// - Current above the lower threshold starts the latch-off counter.
// - Over-current still present after 50 us shuts the device down.
// - Current above the 15 uA upper threshold shuts down at once.
// - Over-current shutdown stays latched until enable goes low.
// - Output 300 mV below reference-minus-droop drives regulator ready low.
// - Output 175 mV above reference forces phases low until enable goes low.
// - After the first over-voltage trip the reference ramps down to zero.
// - At zero after over-voltage, phases stay low, driver enable stays high.
// - Over-voltage fault persists until enable goes low.
// - During soft-start the fixed 2.2 V over-voltage threshold is used.
// - The 4 V ramp supply check is active only while enabled.
module vss_sequencer
  import vss_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic                      enable_in,
  input  wire logic                      vcc_uv_cmp,
  input  wire logic                      ramp_supply_uv_cmp,
  input  wire logic                      driver_enable_in,
  input  wire logic                      current_limit_sense_low_cmp,
  input  wire logic                      current_limit_sense_high_cmp,
  input  wire logic                      out_uv_cmp,
  input  wire logic                      ovp_ref_cmp,
  input  wire logic                      ovp_fixed_cmp,
  input  wire logic                      reduced_phase_mode,
  input  wire logic [1:0]                active_phases,
  input  wire logic [PHASES-1:0]         phase_detect_cmp,
  input  wire logic [PHASES-1:0]         first_pulse,
  input  wire logic [vss_pkg::REF_W-1:0] target_code,
  output var  logic [vss_pkg::REF_W-1:0] ref_code,
  output var  vss_pkg::vss_phase_e       phase_mode [PHASES],
  output var  logic                      test_current_en,
  output var  logic [PHASES-1:0]         phases_present,
  output var  logic                      driver_enable_out,
  output var  logic                      comp_release,
  output var  logic                      regulator_ready_out,
  output var  logic                      current_limit_sense_scale_en,
  output var  logic [1:0]                current_limit_sense_scale_phases,
  output var  logic                      oc_fault,
  output var  logic                      ov_fault
);

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  localparam int unsigned NSYNC = 12 + 2 * PHASES;
  logic [NSYNC-1:0] raw_s;
  logic             en_s, vuv_s, ruv_s, drv_s, ilo_s, ihi_s, ouv_s, ovr_s, ovf_s;
  logic             rpm_s;
  logic [1:0]       aph_s;
  logic [PHASES-1:0] det_s, pul_s;

  vss_sync2 #(.W(NSYNC)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in ({enable_in, vcc_uv_cmp, ramp_supply_uv_cmp, driver_enable_in,
                current_limit_sense_low_cmp, current_limit_sense_high_cmp, out_uv_cmp, ovp_ref_cmp, ovp_fixed_cmp,
                reduced_phase_mode, active_phases, phase_detect_cmp, first_pulse}),
    .sync_out (raw_s)
  );

  assign {en_s, vuv_s, ruv_s, drv_s, ilo_s, ihi_s, ouv_s, ovr_s, ovf_s,
          rpm_s, aph_s, det_s, pul_s} = raw_s;

  // ==========================================================================
  // Sequencer state
  // ==========================================================================
  vss_state_e        st_q, st_d;
  logic [REF_W-1:0]  ref_q, ref_d;
  logic [CNT_W-1:0]  tmr_q, tmr_d;
  logic [CNT_W-1:0]  oc_q, oc_d;
  logic [PHASES-1:0] fired_q, fired_d;
  logic [PHASES-1:0] pres_q, pres_d;
  logic              drv_q, drv_d;
  logic              ok_q, ok_d;
  logic              ocf_q, ocf_d;
  logic              ovf_q, ovf_d;
  logic              supply_uv;
  logic              ov_now;
  logic              step_tick;

  // The ramp supply check is ignored while disabled, as its pin floats then.
  assign supply_uv = vuv_s | (en_s & ruv_s);
  // Reference-relative threshold is unusable while the reference is still low.
  assign ov_now    = (st_q == VSS_ST_RAMP) ? ovf_s : ovr_s;
  assign step_tick = (tmr_q >= CNT_W'(SLEW_STEP_CYC - 1));

  always_comb begin
    st_d    = st_q;
    ref_d   = ref_q;
    tmr_d   = tmr_q;
    oc_d    = oc_q;
    fired_d = fired_q;
    pres_d  = pres_q;
    drv_d   = drv_q;
    ok_d    = ok_q;
    ocf_d   = ocf_q;
    ovf_d   = ovf_q;

    if ((st_q inside {VSS_ST_RAMP, VSS_ST_RUN}) && ilo_s) begin
      oc_d = oc_q + CNT_ONE;
    end else begin
      oc_d = CNT_ZERO;
    end

    case (st_q)
      VSS_ST_OFF: begin
        ref_d   = REF_ZERO;
        drv_d   = 1'b0;
        ok_d    = 1'b0;
        fired_d = '0;
        tmr_d   = CNT_ZERO;
        if (en_s && !supply_uv) begin
          st_d = VSS_ST_DETECT;
        end
      end
      VSS_ST_DETECT: begin
        tmr_d  = tmr_q + CNT_ONE;
        pres_d = det_s;
        if (tmr_q >= CNT_W'(DETECT_CYC - 1)) begin
          tmr_d = CNT_ZERO;
          st_d  = VSS_ST_MIDSET;
        end
      end
      VSS_ST_MIDSET: begin
        drv_d = 1'b1;
        tmr_d = CNT_ZERO;
        // The readback lags by the synchroniser; waiting for it also sits out a driver hold.
        if (drv_q && drv_s) begin
          st_d = VSS_ST_RAMP;
        end
      end
      VSS_ST_RAMP, VSS_ST_RUN: begin
        fired_d = fired_q | (pul_s & pres_q);
        tmr_d   = step_tick ? CNT_ZERO : tmr_q + CNT_ONE;
        if (step_tick && ref_q < target_code) begin
          ref_d = ref_q + REF_STEP;
        end else if (step_tick && ref_q > target_code) begin
          ref_d = ref_q - REF_STEP;
        end
        if (st_q == VSS_ST_RAMP && ref_q == target_code) begin
          st_d = VSS_ST_RUN;
        end
        ok_d = (st_q == VSS_ST_RUN) && !ouv_s;
        if (ov_now) begin
          ovf_d = 1'b1;
          ok_d  = 1'b0;
          tmr_d = CNT_ZERO;
          st_d  = VSS_ST_OVP_DOWN;
        end
      end
      VSS_ST_OVP_DOWN: begin
        ok_d  = 1'b0;
        tmr_d = step_tick ? CNT_ZERO : tmr_q + CNT_ONE;
        if (ref_q == REF_ZERO) begin
          st_d = VSS_ST_OVP_HOLD;
        end else if (step_tick) begin
          ref_d = ref_q - REF_STEP;
        end
      end
      VSS_ST_OVP_HOLD: begin
        ok_d = 1'b0;
      end
      VSS_ST_LATCHED: begin
        drv_d = 1'b0;
        ok_d  = 1'b0;
        ref_d = REF_ZERO;
      end
      default: begin
        st_d = VSS_ST_OFF;
      end
    endcase

    // Over-current shuts down at once on the upper level, or after the timer.
    if ((st_q inside {VSS_ST_RAMP, VSS_ST_RUN}) &&
        (ihi_s || (ilo_s && oc_q >= CNT_W'(OC_LATCH_CYC - 1)))) begin
      ocf_d = 1'b1;
      st_d  = VSS_ST_LATCHED;
      drv_d = 1'b0;
      ok_d  = 1'b0;
    end

    // Driver starvation restarts from mid-level, but not once a fault latched.
    if ((st_q inside {VSS_ST_RAMP, VSS_ST_RUN}) && !drv_s && drv_q &&
        !ov_now && !ocf_d) begin
      st_d    = VSS_ST_MIDSET;
      ref_d   = REF_ZERO;
      fired_d = '0;
      drv_d   = 1'b0;
      ok_d    = 1'b0;
    end

    // Supply loss aborts a start in progress; faults already latched stay.
    if (supply_uv && !ocf_d && !ovf_d &&
        (st_q inside {VSS_ST_DETECT, VSS_ST_MIDSET, VSS_ST_RAMP, VSS_ST_RUN})) begin
      st_d = VSS_ST_OFF;
      drv_d = 1'b0;
      ok_d  = 1'b0;
    end

    if (!en_s) begin
      st_d  = VSS_ST_OFF;
      ocf_d = 1'b0;
      ovf_d = 1'b0;
      drv_d = 1'b0;
      ok_d  = 1'b0;
      ref_d = REF_ZERO;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q    <= VSS_ST_OFF;
      ref_q   <= REF_ZERO;
      tmr_q   <= CNT_ZERO;
      oc_q    <= CNT_ZERO;
      fired_q <= '0;
      pres_q  <= '0;
      drv_q   <= 1'b0;
      ok_q    <= 1'b0;
      ocf_q   <= 1'b0;
      ovf_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      ref_q   <= ref_d;
      tmr_q   <= tmr_d;
      oc_q    <= oc_d;
      fired_q <= fired_d;
      pres_q  <= pres_d;
      drv_q   <= drv_d;
      ok_q    <= ok_d;
      ocf_q   <= ocf_d;
      ovf_q   <= ovf_d;
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ref_code            <= REF_ZERO;
      test_current_en     <= 1'b0;
      phases_present      <= '0;
      driver_enable_out   <= 1'b0;
      comp_release        <= 1'b0;
      regulator_ready_out <= 1'b0;
      current_limit_sense_scale_en       <= 1'b0;
      current_limit_sense_scale_phases   <= 2'h0;
      oc_fault            <= 1'b0;
      ov_fault            <= 1'b0;
      for (int i = 0; i < PHASES; i++) phase_mode[i] <= VSS_PH_OPEN;
    end else begin
      ref_code            <= ref_d;
      test_current_en     <= (st_d == VSS_ST_DETECT);
      phases_present      <= pres_d;
      driver_enable_out   <= drv_d;
      comp_release        <= drv_d && (st_d inside {VSS_ST_RAMP, VSS_ST_RUN});
      regulator_ready_out <= ok_d;
      current_limit_sense_scale_en       <= rpm_s;
      current_limit_sense_scale_phases   <= rpm_s ? aph_s : 2'(PHASES);
      oc_fault            <= ocf_d;
      ov_fault            <= ovf_d;
      for (int i = 0; i < PHASES; i++) begin
        case (st_d)
          VSS_ST_OFF, VSS_ST_DETECT: phase_mode[i] <= VSS_PH_OPEN;
          VSS_ST_MIDSET:             phase_mode[i] <= VSS_PH_MID;
          VSS_ST_RAMP, VSS_ST_RUN:
            phase_mode[i] <= fired_d[i] ? VSS_PH_RUN : VSS_PH_MID;
          default:                   phase_mode[i] <= VSS_PH_LOW;
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  ovp_hold_drv_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q == VSS_ST_OVP_HOLD && en_s) |=> driver_enable_out)
    else $error("Driver enable dropped in over-voltage hold.");

  oc_fast_trip_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q == VSS_ST_RUN && ihi_s && en_s) |=> (st_q == VSS_ST_LATCHED))
    else $error("Upper current level did not shut down at once.");

  oc_latch_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q == VSS_ST_LATCHED && en_s) |=> (st_q == VSS_ST_LATCHED))
    else $error("Over-current latch released without enable low.");

  ovp_phase_low_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q == VSS_ST_OVP_DOWN) |-> ##1 (phase_mode[0] == VSS_PH_LOW || !en_s))
    else $error("Phases not low during over-voltage.");

  ovp_ramp_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q == VSS_ST_OVP_DOWN && ref_q != REF_ZERO && step_tick && en_s)
      |=> (ref_q == $past(ref_q) - REF_STEP))
    else $error("Reference did not step down after over-voltage.");

  ready_low_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q == VSS_ST_RUN && ouv_s) |=> !regulator_ready_out)
    else $error("Ready stayed high on output undervoltage.");

  mid_before_drv_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(driver_enable_out) |-> (phase_mode[0] == VSS_PH_MID))
    else $error("Driver enable rose before mid-level was set.");

  detect_open_a: assert property (@(posedge core_clk) disable iff (srst)
    test_current_en |-> (phase_mode[0] == VSS_PH_OPEN && !driver_enable_out))
    else $error("Test current driven while phases not open.");

  ramp_mono_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q == VSS_ST_RAMP && st_d == VSS_ST_RAMP && ref_q < target_code)
      |=> (ref_q - $past(ref_q) <= REF_STEP))
    else $error("Reference moved faster than one step.");

endmodule : vss_sequencer
`default_nettype wire

/* pkg/vss_pkg.sv */
// Constants and types for the soft-start and fault sequencer.
package vss_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned PHASES    = 3;
  localparam int unsigned REF_W     = 8;
  localparam int unsigned CNT_W     = 16;

  // ==========================================================================
  // Phase output drive states
  // ==========================================================================
  typedef enum logic [1:0] {
    VSS_PH_OPEN,
    VSS_PH_MID,
    VSS_PH_LOW,
    VSS_PH_RUN
  } vss_phase_e;

  typedef enum logic [2:0] {
    VSS_ST_OFF,
    VSS_ST_DETECT,
    VSS_ST_MIDSET,
    VSS_ST_RAMP,
    VSS_ST_RUN,
    VSS_ST_OVP_DOWN,
    VSS_ST_OVP_HOLD,
    VSS_ST_LATCHED
  } vss_state_e;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned OC_LATCH_US      = 50;
  localparam int unsigned OC_LATCH_CYC     = OC_LATCH_US * CLK_MHZ;
  localparam int unsigned DETECT_NS        = 1000;
  localparam int unsigned DETECT_CYC       = (DETECT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLEW_STEP_NS     = 100;
  localparam int unsigned SLEW_STEP_CYC    = (SLEW_STEP_NS * CLK_MHZ) / 1000;

  // ==========================================================================
  // Reset values and increments
  // ==========================================================================
  localparam logic [REF_W-1:0] REF_ZERO    = 8'h00;
  localparam logic [REF_W-1:0] REF_STEP    = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;

endpackage : vss_pkg

/* logic/vss_sync2.sv */
// Two-flop synchroniser for a vector of comparator levels.
`timescale 1ns/1ps
`default_nettype none
module vss_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : vss_sync2
`default_nettype wire

/* tb/vss_drv_model.sv */
// Behavioural gate driver and power stage facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module vss_drv_model #(
  parameter int unsigned HOLD = 20
) (
  input  wire logic       core_clk,
  input  wire logic       drv_uv,
  input  wire logic       driver_enable_out,
  input  wire logic [2:0] pulse_go,
  output var  logic       driver_enable_in,
  output var  logic [2:0] first_pulse
);
  int unsigned hold_q = 0;
  // ==========================================================================
  // Driver undervoltage
  // ==========================================================================
  // The line stays low a while after the fault so the controller can restart.
  always @(posedge core_clk) begin
    if (drv_uv) begin
      hold_q <= HOLD;
    end else if (hold_q != 0) begin
      hold_q <= hold_q - 1;
    end
  end
  // The shared line reads low whenever nobody drives it high.
  always_comb driver_enable_in = driver_enable_out && !drv_uv && hold_q == 0;
  // Pulses only come while the drivers are allowed to switch.
  always_comb first_pulse = driver_enable_in ? pulse_go : 3'h0;
endmodule : vss_drv_model
`default_nettype wire

/* tb/vss_sequencer_tb_top.sv */
// Self-checking testbench for the soft-start and fault sequencer.
`timescale 1ns/1ps
`default_nettype none
module vss_sequencer_tb_top;
  import vss_pkg::*;
  logic core_clk, srst, enable_in, vcc_uv_cmp, ramp_supply_uv_cmp, driver_enable_in;
  logic current_limit_sense_low_cmp, current_limit_sense_high_cmp, out_uv_cmp, ovp_ref_cmp, ovp_fixed_cmp;
  logic reduced_phase_mode, test_current_en, driver_enable_out, comp_release;
  logic regulator_ready_out, current_limit_sense_scale_en, oc_fault, ov_fault, drv_uv;
  logic [1:0] active_phases, current_limit_sense_scale_phases;
  logic [2:0] phase_detect_cmp, first_pulse, phases_present, pulse_go;
  logic [7:0] target_code, ref_code;
  vss_phase_e phase_mode [PHASES];
  int err_total = 0;
  int checked = 0;

  vss_sequencer vss_sequencer_inst (
    .core_clk(core_clk), .srst(srst), .enable_in(enable_in), .vcc_uv_cmp(vcc_uv_cmp),
    .ramp_supply_uv_cmp(ramp_supply_uv_cmp), .driver_enable_in(driver_enable_in),
    .current_limit_sense_low_cmp(current_limit_sense_low_cmp), .current_limit_sense_high_cmp(current_limit_sense_high_cmp), .out_uv_cmp(out_uv_cmp),
    .ovp_ref_cmp(ovp_ref_cmp), .ovp_fixed_cmp(ovp_fixed_cmp),
    .reduced_phase_mode(reduced_phase_mode), .active_phases(active_phases),
    .phase_detect_cmp(phase_detect_cmp), .first_pulse(first_pulse),
    .target_code(target_code), .ref_code(ref_code), .phase_mode(phase_mode),
    .test_current_en(test_current_en), .phases_present(phases_present),
    .driver_enable_out(driver_enable_out), .comp_release(comp_release),
    .regulator_ready_out(regulator_ready_out), .current_limit_sense_scale_en(current_limit_sense_scale_en),
    .current_limit_sense_scale_phases(current_limit_sense_scale_phases), .oc_fault(oc_fault), .ov_fault(ov_fault));

  vss_drv_model vss_drv_model_inst (
    .core_clk(core_clk), .drv_uv(drv_uv), .driver_enable_out(driver_enable_out),
    .pulse_go(pulse_go), .driver_enable_in(driver_enable_in), .first_pulse(first_pulse));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic chk_ph(string n, vss_phase_e e, vss_phase_e g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %0d got %0d", n, e, g);
    end
  endtask : chk_ph

  task automatic up(logic [7:0] t);
    target_code = t;
    enable_in = 1'b1;
    for (int i = 0; i < 400 && regulator_ready_out !== 1'b1; i++) cyc(1);
    pulse_go = 3'h7;
    cyc(5);
  endtask : up

  // Dropping enable is the only way out of a latched fault.
  task automatic off;
    {enable_in, current_limit_sense_low_cmp, current_limit_sense_high_cmp, ovp_ref_cmp, ovp_fixed_cmp} = 5'h00;
    {out_uv_cmp, vcc_uv_cmp, ramp_supply_uv_cmp, reduced_phase_mode} = 4'h0;
    pulse_go = 3'h0;
    cyc(10);
  endtask : off

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_start;
    int n;
    target_code = 8'h04;
    enable_in = 1'b1;
    cyc(10);
    chk("test_cur", 8'h01, test_current_en);
    chk_ph("ph_open", VSS_PH_OPEN, phase_mode[0]);
    chk("drv_early", 8'h00, driver_enable_out);
    for (int i = 0; i < 200 && driver_enable_out !== 1'b1; i++) cyc(1);
    chk("present", 8'h05, phases_present);
    chk("full_ph", 8'(PHASES), current_limit_sense_scale_phases);
    for (int p = 0; p < PHASES; p++) chk_ph("ph_mid", VSS_PH_MID, phase_mode[p]);
    chk("ref_zero", 8'h00, ref_code);
    for (int i = 0; i < 30 && ref_code !== 8'h01; i++) cyc(1);
    chk("comp_rel", 8'h01, comp_release);
    n = 0;
    while (n < 30 && ref_code === 8'h01) begin
      cyc(1);
      n++;
    end
    chk("slew", 8'(SLEW_STEP_CYC), 8'(n));
    for (int i = 0; i < 100 && regulator_ready_out !== 1'b1; i++) cyc(1);
    chk("ref_top", 8'h04, ref_code);
    chk_ph("ph_hold", VSS_PH_MID, phase_mode[0]);
    pulse_go = 3'h1;
    cyc(5);
    chk_ph("ph_run", VSS_PH_RUN, phase_mode[0]);
    chk_ph("ph_wait", VSS_PH_MID, phase_mode[1]);
    off();
  endtask : t_start

  task automatic t_drv_uv;
    up(8'h03);
    drv_uv = 1'b1;
    cyc(2);
    drv_uv = 1'b0;
    cyc(6);
    chk_ph("uv_mid", VSS_PH_MID, phase_mode[2]);
    chk("uv_ref", 8'h00, ref_code);
    for (int i = 0; i < 400 && regulator_ready_out !== 1'b1; i++) cyc(1);
    chk("uv_again", 8'h01, regulator_ready_out);
    off();
  endtask : t_drv_uv

  task automatic t_oc;
    up(8'h02);
    current_limit_sense_low_cmp = 1'b1;
    cyc(OC_LATCH_CYC - 50);
    chk("oc_early", 8'h00, oc_fault);
    for (int i = 0; i < 100 && oc_fault !== 1'b1; i++) cyc(1);
    chk("oc_latch", 8'h01, oc_fault);
    current_limit_sense_low_cmp = 1'b0;
    cyc(20);
    chk("oc_held", 8'h01, oc_fault);
    chk_ph("oc_ph", VSS_PH_LOW, phase_mode[1]);
    chk("oc_rdy", 8'h00, regulator_ready_out);
    off();
    chk("oc_clr", 8'h00, oc_fault);
    up(8'h02);
    current_limit_sense_high_cmp = 1'b1;
    cyc(2);
    current_limit_sense_high_cmp = 1'b0;
    cyc(6);
    chk("oc_fast", 8'h01, oc_fault);
    off();
  endtask : t_oc

  task automatic t_ov;
    int n;
    up(8'h04);
    ovp_ref_cmp = 1'b1;
    cyc(6);
    chk_ph("ov_ph", VSS_PH_LOW, phase_mode[0]);
    ovp_ref_cmp = 1'b0;
    n = 0;
    while (n < 100 && ref_code !== 8'h00) begin
      cyc(1);
      n++;
    end
    chk("ov_slow", 8'h01, 8'(n >= 3 * SLEW_STEP_CYC));
    chk("ov_zero", 8'h00, ref_code);
    cyc(5);
    chk("ov_drv", 8'h01, driver_enable_out);
    chk_ph("ov_hold", VSS_PH_LOW, phase_mode[2]);
    chk("ov_held", 8'h01, ov_fault);
    off();
    chk("ov_clr", 8'h00, ov_fault);
    target_code = 8'h40;
    enable_in = 1'b1;
    cyc(150);
    ovp_ref_cmp = 1'b1;
    cyc(6);
    chk("ss_ref", 8'h00, ov_fault);
    ovp_ref_cmp = 1'b0;
    ovp_fixed_cmp = 1'b1;
    cyc(6);
    chk("ss_fix", 8'h01, ov_fault);
    off();
  endtask : t_ov

  task automatic t_mon;
    up(8'h02);
    out_uv_cmp = 1'b1;
    cyc(6);
    chk("out_uv", 8'h00, regulator_ready_out);
    out_uv_cmp = 1'b0;
    reduced_phase_mode = 1'b1;
    active_phases = 2'h2;
    cyc(6);
    chk("uv_back", 8'h01, regulator_ready_out);
    chk("shed_en", 8'h01, current_limit_sense_scale_en);
    chk("shed_ph", 8'h02, current_limit_sense_scale_phases);
    vcc_uv_cmp = 1'b1;
    cyc(6);
    chk("vcc_uv", 8'h00, driver_enable_out);
    vcc_uv_cmp = 1'b0;
    cyc(300);
    ramp_supply_uv_cmp = 1'b1;
    cyc(6);
    chk("ramp_uv", 8'h00, regulator_ready_out);
    off();
  endtask : t_mon

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // The longest path is the over-current timer; the rest is under two thousand cycles.
  initial begin
    repeat (30000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    drv_uv = 1'b0;
    active_phases = 2'h0;
    phase_detect_cmp = 3'h5;
    target_code = 8'h00;
    off();
    srst = 1'b0;
    cyc(3);
    t_start();
    t_drv_uv();
    t_oc();
    t_ov();
    t_mon();
    give_verdict();
  end
endmodule : vss_sequencer_tb_top
`default_nettype wire
